// file: src/epc_cfg.svh
// Constants of the external memory port control block.
// Assumes inclusion by bare name from every file that needs offsets.
// Overview of operation
// R1: DM boot-space enable set routes data-bus accesses to the boot select
// R2: Each space has 3-bit read and write waitstate counts, 0 to 7
// R3: Mode 00 ends only on acknowledge, with at least two waitstates
// R4: Mode 01 times reads and writes from their counts, ignores ack
// R5: Mode 10 needs both count expiry and acknowledge
// R6: Mode 11 ends at count expiry or acknowledge, whichever first
// R7: Write hold keeps address and data one cycle after write strobe
// R8: Write hold applies in every waitstate mode
// R9: Divider codes 000 to 101 give 1:1 up to 1:32 memory clock; code 000 drives memory_side_clock at 1:2, as code 001 does
// R10: Divider chosen per bank or space, paces setup and strobe
// R11: After reset four banks of 63 or 64 pages each
// R12: Bank 0 starts at 0x10000; an address in a bank asserts its select
// R13: Write pending flag reads 1 while an external write is outstanding
// R14: Bus busy field: 00 idle, 01 off-chip master, 10 on-chip master
// R15: Five-bit field holds identity of current or last port master
// R16: Two-bit field reports bytes held in the word packer
// R17: Core is not stalled waiting for an external write to finish
// R18: Bus request is active low and asynchronous
// R19: With no access, grant next cycle after floating all drivers
// R20: Request during an access is granted the cycle after it completes
// R21: Grant released in the cycle request removal is seen
// R22: Control layout: read 2-0, write 5-3, mode 7-6, divider 10-8
// R23: Bus request passes a two-stage synchroniser
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH
`define EPC_OFF_ESTAT 8'h00
`define EPC_OFF_PSTAT 8'h04
`define EPC_OFF_CTL0  8'h08
`define EPC_OFF_CTL1  8'h0C
`define EPC_OFF_CTL2  8'h10
`define EPC_OFF_CTL3  8'h14
`define EPC_OFF_CTLB  8'h18
`define EPC_OFF_CTLI  8'h1C
`define EPC_OFF_PG10  8'h20
`define EPC_OFF_PG32  8'h24
`define EPC_DDBE_BIT  2
`define EPC_WPF_BIT   8
`define EPC_RWC_LSB   0
`define EPC_WWC_LSB   3
`define EPC_WMS_LSB   6
`define EPC_CDS_LSB   8
`define EPC_WHE_BIT   11
`define EPC_BSY_LSB   0
`define EPC_MID_LSB   2
`define EPC_WPS_LSB   7
`define EPC_CTL_RST   12'h0FF
`define EPC_PG10_RST  16'h4001
`define EPC_PG32_RST  16'hC080
`define EPC_ACK_MINWS 3'h2
`endif

// file: src/epc_pkg.sv
// Types shared by the external memory port control modules.
// Assumes epc_cfg.svh supplies the numeric constants.
package epc_pkg;
  typedef enum logic [2:0] {
    EPC_IDLE  = 3'b000,
    EPC_SETUP = 3'b001,
    EPC_STRB  = 3'b010,
    EPC_HOLD  = 3'b011,
    EPC_GRNT  = 3'b100
  } epc_state_t;
  typedef enum logic [1:0] {
    EPC_WMS_ACK    = 2'b00,
    EPC_WMS_WAIT   = 2'b01,
    EPC_WMS_BOTH   = 2'b10,
    EPC_WMS_EITHER = 2'b11
  } epc_wms_t;
  typedef enum logic [1:0] {
    EPC_BSY_NONE = 2'b00,
    EPC_BSY_OFF  = 2'b01,
    EPC_BSY_ON   = 2'b10
  } epc_bsy_t;
endpackage : epc_pkg

// file: src/epc_div_if.sv
// Divider select and memory clock pacing between the port and divider.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface epc_div_if;
  logic [2:0] cds;
  logic       tick;
  logic       mclk;
  modport div  (input cds, output tick, output mclk);
  modport user (output cds, input tick, input mclk);
endinterface : epc_div_if

// file: src/epc_sync.sv
// Two-stage synchroniser for pins from outside the clock domain.
// Assumes ce freezes it with the rest of the block.
`timescale 1ns/1ps
module epc_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST;
      dout   <= RST;
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : epc_sync

// file: src/epc_clkdiv.sv
// Memory clock divider: tick marks each memory clock period.
// Assumes cds codes above 101 are treated as 1:32.
`timescale 1ns/1ps
`include "epc_cfg.svh"
module epc_clkdiv (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  epc_div_if.div    dv
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] lim;
  logic       mclk_q;
  logic       mclk_d;
  // Period minus one per divider code
  assign lim = (dv.cds > 3'h5) ? 5'h1F
             : 5'((6'h01 << dv.cds) - 6'h01); // R9
  assign dv.tick = (cnt_q >= lim); // R10
  assign cnt_d   = dv.tick ? 5'h00 : cnt_q + 5'h01;
  // At 1:1 the output can only toggle, so it shows half rate
  assign mclk_d  = (lim == 5'h00) ? ~mclk_q : (cnt_d > (lim >> 1));
  assign dv.mclk = mclk_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 5'h00;
      mclk_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      mclk_q <= mclk_d;
    end
  end
endmodule : epc_clkdiv

// file: src/epc_top.sv
// External memory port control: APB registers, bank decode,
// waitstate sequencing, write hold and external bus grant.
// Assumes core requests on clk; ack, data and bus request are pins.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "epc_cfg.svh"
module epc_top #(
  parameter logic [4:0] EXT_MID = 5'h1F, // arbitrary off-chip master id
  parameter int         AW      = 24
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          ce,
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic          req_io,
  input  wire logic          req_dm,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [15:0]   req_wdata,
  input  wire logic [4:0]    req_mid,
  output logic               req_ready,
  output logic               rd_valid,
  output logic      [15:0]   rd_data,
  input  wire logic [1:0]    packer_fill,
  input  wire logic          ack,
  input  wire logic          bus_request_n,
  output logic               bus_grant_n,
  output logic      [AW-1:0] mem_addr_o,
  output logic               mem_addr_oe,
  input  wire logic [15:0]   mem_data_i,
  output logic      [15:0]   mem_data_o,
  output logic               mem_data_oe,
  output logic      [3:0]    bank_select_bus_n,
  output logic               boot_space_select_n,
  output logic               io_space_select_n,
  output logic               select_oe,
  output logic               rd_n,
  output logic               wr_n,
  output logic               strobe_oe,
  output logic               memory_side_clock
);
  import epc_pkg::*;

  epc_state_t  st_q;
  epc_state_t  st_d;
  logic [11:0] ctl_q [6];
  logic [15:0] pg10_q;
  logic [15:0] pg32_q;
  logic        ddbe_q;
  logic        wpend_q;
  logic [4:0]  mid_q;
  logic [11:0] act_q;
  logic        wr_q;
  logic [2:0]  wcnt_q;
  logic [3:0]  bank_n_q;
  logic        boot_n_q;
  logic        io_n_q;
  logic [31:0] prdata_q;
  logic        rdv_q;
  logic [15:0] rdd_q;
  logic [AW-1:0] addr_q;
  logic [15:0] wdat_q;
  logic        br_s;
  logic        ack_s;
  logic [15:0] din_s;
  epc_div_if   dvi ();

  // Pins from outside pass two flip-flops before use
  epc_sync #(.W(1), .RST(1'b1)) u_br_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .din     (bus_request_n),
    .dout    (br_s)
  ); // R18 R23
  epc_sync #(.W(17), .RST(17'h00000)) u_ack_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .din     ({ack, mem_data_i}),
    .dout    ({ack_s, din_s})
  );
  epc_clkdiv u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .dv      (dvi.div)
  );

  // Bank decode on the 8-bit page number
  wire [7:0] page = req_addr[AW-1:AW-8];
  wire [7:0] lo [4];
  wire [3:0] bank_hit;
  assign lo[0] = pg10_q[7:0];
  assign lo[1] = pg10_q[15:8];
  assign lo[2] = pg32_q[7:0];
  assign lo[3] = pg32_q[15:8];
  for (genvar i = 0; i < 4; i++) begin : g_bank
    if (i == 3) begin : g_last
      assign bank_hit[i] = (page >= lo[i]); // R12
    end else begin : g_mid
      assign bank_hit[i] = (page >= lo[i]) && (page < lo[i+1]); // R12
    end
  end

  // Space selection for a new request
  wire use_boot = req_dm && ddbe_q && !req_io; // R1
  wire [3:0] bank_sel = (use_boot || req_io) ? 4'h0
                      : bank_hit & ~(bank_hit >> 1)
                        & ~(bank_hit >> 2) & ~(bank_hit >> 3);
  wire [2:0] ctl_idx = req_io   ? 3'h5
                     : use_boot ? 3'h4
                     : bank_hit[3] ? 3'h3
                     : bank_hit[2] ? 3'h2
                     : bank_hit[1] ? 3'h1 : 3'h0;
  wire [11:0] new_ctl = ctl_q[ctl_idx];

  // Fields of the active control word
  wire [2:0] rwc  = act_q[`EPC_RWC_LSB +: 3]; // R22
  wire [2:0] wwc  = act_q[`EPC_WWC_LSB +: 3]; // R22
  wire [1:0] wms  = act_q[`EPC_WMS_LSB +: 2]; // R22
  wire       whe  = act_q[`EPC_WHE_BIT];
  wire [2:0] ws   = wr_q ? wwc : rwc; // R2
  wire       cnt_ok = (wcnt_q >= ws); // R2
  assign dvi.cds  = act_q[`EPC_CDS_LSB +: 3]; // R10
  assign memory_side_clock = dvi.mclk;

  // Completion condition for each waitstate mode
  wire done_ack    = ack_s && (wcnt_q >= `EPC_ACK_MINWS); // R3
  wire done_wait   = cnt_ok; // R4
  wire done_both   = cnt_ok && ack_s; // R5
  wire done_either = cnt_ok || ack_s; // R6
  wire strb_done = (wms == EPC_WMS_ACK)  ? done_ack
                 : (wms == EPC_WMS_WAIT) ? done_wait
                 : (wms == EPC_WMS_BOTH) ? done_both : done_either;
  wire strb_end  = (st_q == EPC_STRB) && dvi.tick && strb_done;
  wire br_act    = !br_s;
  wire take      = (st_q == EPC_IDLE) && !br_act && req_valid;
  wire acc_end   = (strb_end && !(wr_q && whe))
                 || ((st_q == EPC_HOLD) && dvi.tick);

  // Access and grant sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      EPC_IDLE: begin
        if (br_act) st_d = EPC_GRNT; // R19 R20
        else if (req_valid) st_d = EPC_SETUP;
      end
      EPC_SETUP: begin
        if (dvi.tick) st_d = EPC_STRB; // R10
      end
      EPC_STRB: begin
        if (strb_end) st_d = (wr_q && whe) ? EPC_HOLD // R7 R8
                                           : EPC_IDLE;
      end
      EPC_HOLD: begin
        if (dvi.tick) st_d = EPC_IDLE; // R7
      end
      EPC_GRNT: begin
        if (!br_act) st_d = EPC_IDLE; // R21
      end
      default: st_d = EPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_q <= EPC_IDLE;
    else if (ce)  st_q <= st_d;
  end

  // Waitstate counter runs in memory clock periods of the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wcnt_q <= 3'h0;
    else if (ce) begin
      if (st_q != EPC_STRB) wcnt_q <= 3'h0;
      else if (dvi.tick && wcnt_q != 3'h7) wcnt_q <= wcnt_q + 3'h1;
    end
  end

  // Request capture; writes are taken without waiting for completion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act_q    <= `EPC_CTL_RST;
      wr_q     <= 1'b0;
      addr_q   <= '0;
      wdat_q   <= 16'h0000;
      bank_n_q <= 4'hF;
      boot_n_q <= 1'b1;
      io_n_q   <= 1'b1;
    end else if (ce) begin
      if (take) begin
        act_q    <= new_ctl;
        wr_q     <= req_write;
        addr_q   <= req_addr;
        wdat_q   <= req_wdata;
        bank_n_q <= ~bank_sel; // R12
        boot_n_q <= !use_boot; // R1
        io_n_q   <= !req_io;
      end else if (acc_end) begin
        bank_n_q <= 4'hF;
        boot_n_q <= 1'b1;
        io_n_q   <= 1'b1;
      end
    end
  end

  // Read data return, pending flag and master identity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdv_q   <= 1'b0;
      rdd_q   <= 16'h0000;
      wpend_q <= 1'b0;
      mid_q   <= 5'h00;
    end else if (ce) begin
      rdv_q <= strb_end && !wr_q;
      if (strb_end && !wr_q) rdd_q <= din_s;
      if (take && req_write) wpend_q <= 1'b1; // R13 R17
      else if (acc_end) wpend_q <= 1'b0; // R13
      if (take) mid_q <= req_mid; // R15
      else if (st_q == EPC_IDLE && br_act) mid_q <= EXT_MID; // R15
    end
  end

  // Pin drive; grant floats every driver
  wire drive = (st_q != EPC_GRNT); // R19
  wire in_acc = (st_q == EPC_SETUP) || (st_q == EPC_STRB)
             || (st_q == EPC_HOLD);
  assign req_ready   = take;
  assign rd_valid    = rdv_q;
  assign rd_data     = rdd_q;
  assign mem_addr_o  = addr_q;
  assign mem_data_o  = wdat_q;
  assign mem_addr_oe = drive;
  assign mem_data_oe = drive && in_acc && wr_q; // R7
  assign select_oe   = drive;
  assign strobe_oe   = drive;
  assign bank_select_bus_n   = bank_n_q;
  assign boot_space_select_n = boot_n_q;
  assign io_space_select_n   = io_n_q;
  assign rd_n = !((st_q == EPC_STRB) && !wr_q);
  assign wr_n = !((st_q == EPC_STRB) && wr_q); // R7
  assign bus_grant_n = !((st_q == EPC_GRNT) && br_act); // R21

  // Status words
  wire [1:0] bsy = (st_q == EPC_GRNT) ? EPC_BSY_OFF // R14
                 : in_acc ? EPC_BSY_ON : EPC_BSY_NONE; // R14
  wire [15:0] estat = (16'(wpend_q) << `EPC_WPF_BIT)
                    | (16'(ddbe_q) << `EPC_DDBE_BIT); // R13
  wire [15:0] pstat = (16'(packer_fill) << `EPC_WPS_LSB) // R16
                    | (16'(mid_q) << `EPC_MID_LSB)
                    | (16'(bsy) << `EPC_BSY_LSB);

  // APB decode
  wire a_es = (paddr == `EPC_OFF_ESTAT);
  wire a_ps = (paddr == `EPC_OFF_PSTAT);
  wire a_ct = (paddr >= `EPC_OFF_CTL0) && (paddr <= `EPC_OFF_CTLI)
           && (paddr[1:0] == 2'b00);
  wire a_p0 = (paddr == `EPC_OFF_PG10);
  wire a_p1 = (paddr == `EPC_OFF_PG32);
  wire a_ok = a_es || a_ps || a_ct || a_p0 || a_p1;
  wire [7:0] ct_off = paddr - `EPC_OFF_CTL0;
  wire [2:0] ct_i   = ct_off[4:2];
  wire wr_en = psel && penable && pwrite && a_ok;
  wire [15:0] rmux = a_es ? estat
                   : a_ps ? pstat
                   : a_ct ? {4'h0, ctl_q[ct_i]}
                   : a_p0 ? pg10_q
                   : a_p1 ? pg32_q : 16'h0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !a_ok;
  assign prdata  = prdata_q;

  // Read data is loaded in the setup phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) prdata_q <= 32'h00000000;
    else if (ce && psel && !penable) prdata_q <= {16'h0000, rmux};
  end

  // Software-written registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < 6; k++) ctl_q[k] <= `EPC_CTL_RST;
      pg10_q <= `EPC_PG10_RST; // R11
      pg32_q <= `EPC_PG32_RST; // R11
      ddbe_q <= 1'b0;
    end else if (ce && wr_en) begin
      if (a_es) ddbe_q <= pwdata[`EPC_DDBE_BIT]; // R1
      if (a_ct) ctl_q[ct_i] <= pwdata[11:0]; // R22
      if (a_p0) pg10_q <= pwdata[15:0];
      if (a_p1) pg32_q <= pwdata[15:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr_end;
    ce && strb_end && wr_q && whe;
  endsequence
  sequence s_hold;
    st_q == EPC_HOLD && wr_n && $stable(mem_addr_o)
      && mem_data_oe;
  endsequence

  property p_boot_sel;
    ce && take && use_boot |=> !boot_space_select_n
      && bank_select_bus_n == 4'hF;
  endproperty
  a_boot_sel: assert property (p_boot_sel) // R1
    else $error("boot select not asserted");
  property p_bank_sel;
    ce && take && !use_boot && !req_io && bank_hit == 4'h1
      |=> bank_select_bus_n == 4'hE;
  endproperty
  a_bank_sel: assert property (p_bank_sel) // R12
    else $error("bank 0 select wrong");
  property p_ack_min;
    strb_end && wms == EPC_WMS_ACK |-> ack_s && wcnt_q >= 3'h2;
  endproperty
  a_ack_min: assert property (p_ack_min) // R3
    else $error("ack mode ended early");
  property p_wait;
    strb_end && wms == EPC_WMS_WAIT
      |-> wcnt_q >= (wr_q ? wwc : rwc);
  endproperty
  a_wait: assert property (p_wait) // R4
    else $error("wait mode ended before count");
  property p_both;
    strb_end && wms == EPC_WMS_BOTH |-> ack_s && cnt_ok;
  endproperty
  a_both: assert property (p_both) // R5
    else $error("both mode ended without ack and count");
  property p_either;
    ce && st_q == EPC_STRB && dvi.tick && wms == EPC_WMS_EITHER
      && ack_s |=> st_q != EPC_STRB;
  endproperty
  a_either: assert property (p_either) // R6
    else $error("either mode ignored ack");
  property p_hold;
    s_wr_end |=> s_hold;
  endproperty
  a_hold: assert property (p_hold) // R7 R8
    else $error("write hold cycle missing");
  property p_grant;
    ce && st_q == EPC_IDLE && br_act ##1 br_act |-> !bus_grant_n
      && !mem_addr_oe && !select_oe && !strobe_oe;
  endproperty
  a_grant: assert property (p_grant) // R19 R20
    else $error("grant not given next cycle");
  property p_release;
    ce && st_q == EPC_GRNT && !br_act |-> bus_grant_n ##1 mem_addr_oe;
  endproperty
  a_release: assert property (p_release) // R21
    else $error("grant not released with request");
  property p_wpf;
    ce && take && req_write |=> wpend_q ##0 estat[`EPC_WPF_BIT];
  endproperty
  a_wpf: assert property (p_wpf) // R13
    else $error("write pending flag not set");
endmodule : epc_top

// file: bench/epc_mem_model.sv
// External memory model facing the port: drives a word made from the
// address while selected for a read and raises acknowledge after a set delay.
// Assumes active-low strobes and selects from the port.
`timescale 1ns/1ps
module epc_mem_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        sel_n,
  input  wire logic        mem_data_oe,
  input  wire logic [23:0] mem_addr_o,
  input  wire logic [7:0]  ack_dly,
  output logic             ack,
  output logic      [15:0] mem_data_i
);
  logic [7:0]  cnt_q;
  logic [15:0] last_q;
  logic        strobe;
  logic        drive;
  // Strobe seen and bus driven by the memory
  assign strobe = !rd_n || !wr_n;
  assign drive  = !sel_n && wr_n && !mem_data_oe;
  // Saturating count of strobe cycles; last driven word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 8'h00;
      last_q <= 16'h0000;
    end else begin
      cnt_q <= !strobe ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
      if (drive) begin
        last_q <= mem_data_i;
      end
    end
  end
  // Zero delay holds ack high; else it rises late in the strobe
  assign ack = (ack_dly == 8'h00) || (strobe && cnt_q >= ack_dly);
  // A released bus shows the inverse of the last word
  assign mem_data_i = drive ? mem_addr_o[15:0] ^ 16'hA5C3 : ~last_q;
endmodule : epc_mem_model

// file: bench/external_memory_port_control_bench.sv
// Self-checking bench for the external memory port control block.
// Assumes epc_top with default parameters and the memory model.
`timescale 1ns/1ps
`include "epc_cfg.svh"
module external_memory_port_control_bench;
  import epc_pkg::*;
  localparam logic [23:0] A0 = 24'h010010;
  logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, ack_dly;
  logic [31:0] pwdata, prdata, r;
  logic        req_valid, req_write, req_io, req_dm, req_ready, rd_valid;
  logic [23:0] req_addr, mem_addr_o;
  logic [15:0] req_wdata, rd_data, mem_data_i, mem_data_o, g_rd;
  logic [4:0]  req_mid;
  logic [1:0]  packer_fill;
  logic        ack, bus_request_n, bus_grant_n, mem_addr_oe, mem_data_oe;
  logic [3:0]  bank_select_bus_n;
  logic        boot_space_select_n, io_space_select_n, select_oe, e;
  logic        rd_n, wr_n, strobe_oe, memory_side_clock, overlap;
  logic [5:0]  g_sel;
  int          fails, n_compared, g_len, g_hc, base;

  epc_top dut_u (.clk, .reset_n, .ce, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_write, .req_io,
    .req_dm, .req_addr, .req_wdata, .req_mid, .req_ready, .rd_valid,
    .rd_data, .packer_fill, .ack, .bus_request_n, .bus_grant_n,
    .mem_addr_o, .mem_addr_oe, .mem_data_i, .mem_data_o, .mem_data_oe,
    .bank_select_bus_n, .boot_space_select_n, .io_space_select_n,
    .select_oe, .rd_n, .wr_n, .strobe_oe, .memory_side_clock);
  epc_mem_model mem_u (.clk, .reset_n, .rd_n, .wr_n, .mem_data_oe,
    .mem_addr_o, .ack_dly, .ack, .mem_data_i,
    .sel_n(&{bank_select_bus_n, boot_space_select_n, io_space_select_n}));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Flags a read strobe driven while the bus is granted away
  always @(posedge clk) begin
    if (strobe_oe === 1'b1 && rd_n === 1'b0 && bus_grant_n === 1'b0) begin
      overlap <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input int idx, input logic [2:0] rwc, wwc,
                      input logic [1:0] m, input logic [2:0] cds,
                      input logic whe);
    apb(1'b1, 8'(`EPC_OFF_CTL0 + 4 * idx), {20'h0, whe, cds, m, wwc, rwc});
  endtask : setc

  // Core access: strobe length, selects, hold cycles and read data
  task automatic acc(input logic w, dm, input logic [23:0] a);
    int k;
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_dm    <= dm;
    req_addr  <= a;
    req_wdata <= ~a[15:0];
    do begin
      @(posedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    req_valid <= 1'b0;
    g_len = 0;
    g_hc  = 0;
    k     = 0;
    for (int i = 0; i < 3000 && k < 70; i++) begin
      @(posedge clk);
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        g_len++;
        g_sel = {boot_space_select_n, io_space_select_n, bank_select_bus_n};
      end else if (g_len > 0) begin
        k++;
        if (w && k == g_hc + 1 && mem_data_oe === 1'b1 &&
            mem_data_o === ~a[15:0] && mem_addr_o === a) g_hc++;
      end
      if (rd_valid === 1'b1) g_rd = rd_data;
    end
  endtask : acc

  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(`EPC_OFF_CTL0 + 4 * i), 32'h0);
      check("control reset", r, 32'h0FF);
    end
    apb(1'b0, `EPC_OFF_PG10, 32'h0);
    check("bank 1:0 pages", r, 32'h4001);
    apb(1'b0, `EPC_OFF_PG32, 32'h0);
    check("bank 3:2 pages", r, 32'hC080);
    apb(1'b1, `EPC_OFF_ESTAT, 32'h100);
    apb(1'b0, `EPC_OFF_ESTAT, 32'h0);
    check("pending flag read only", r[8], 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", e, 1'b1);
  endtask : t_regs

  task automatic t_decode();
    logic [7:0] pg [6] = '{8'h01, 8'h3F, 8'h40, 8'h80, 8'hC0, 8'hFF};
    logic [3:0] bk [6] = '{4'hE, 4'hE, 4'hD, 4'hB, 4'h7, 4'h7};
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 1'b0, {pg[i], 16'h1234});
      check("bank select", g_sel, {2'h3, bk[i]});
      check("read data", g_rd, 16'h1234 ^ 16'hA5C3);
    end
    apb(1'b1, `EPC_OFF_ESTAT, 32'h4);
    acc(1'b0, 1'b1, A0);
    check("boot select", g_sel, 6'h1F);
    acc(1'b0, 1'b0, A0);
    check("bank kept", g_sel, 6'h3E);
    apb(1'b1, `EPC_OFF_ESTAT, 32'h0);
    acc(1'b0, 1'b1, A0);
    check("boot off", g_sel, 6'h3E);
  endtask : t_decode

  task automatic mrow(input logic [1:0] m, input logic [2:0] ws,
                      input logic [7:0] d, input int x, input logic gt);
    setc(0, ws, 3'h0, m, 3'h0, 1'b0);
    ack_dly <= d;
    acc(1'b0, 1'b0, A0);
    if (gt) begin
      check("stretched strobe", g_len > base + x, 1);
    end else begin
      check("strobe length", g_len, base + x);
    end
  endtask : mrow

  task automatic t_modes();
    setc(0, 3'h0, 3'h0, 2'h1, 3'h0, 1'b0);
    acc(1'b0, 1'b0, A0);
    base = g_len;
    mrow(2'h1, 3'h3, 8'd0, 3, 1'b0);
    mrow(2'h1, 3'h7, 8'd0, 7, 1'b0);
    mrow(2'h0, 3'h0, 8'd0, 2, 1'b0);
    mrow(2'h0, 3'h0, 8'd12, 2, 1'b1);
    mrow(2'h2, 3'h5, 8'd0, 5, 1'b0);
    mrow(2'h2, 3'h1, 8'd12, 1, 1'b1);
    mrow(2'h3, 3'h5, 8'd0, 0, 1'b0);
    mrow(2'h3, 3'h5, 8'd20, 5, 1'b0);
  endtask : t_modes

  task automatic t_div();
    int l0, nr;
    logic pm;
    for (int k = 0; k < 6; k++) begin
      setc(0, 3'h0, 3'h0, 2'h1, 3'(k), 1'b0);
      acc(1'b0, 1'b0, A0);
      l0 = g_len;
      nr = 0;
      repeat (64) begin
        pm = memory_side_clock;
        @(posedge clk);
        if (!pm && memory_side_clock) nr++;
      end
      check("memory clock rises", nr, 64 >> (k ? k : 1));
      setc(0, 3'h1, 3'h0, 2'h1, 3'(k), 1'b0);
      acc(1'b0, 1'b0, A0);
      check("waitstate per divider", g_len - l0, 1 << k);
    end
    setc(1, 3'h0, 3'h0, 2'h1, 3'h0, 1'b0);
    acc(1'b0, 1'b0, 24'h400010);
    l0 = g_len;
    setc(1, 3'h1, 3'h0, 2'h1, 3'h0, 1'b0);
    acc(1'b0, 1'b0, 24'h400010);
    check("bank own divider", g_len - l0, 1);
  endtask : t_div

  task automatic t_write();
    int h0;
    ack_dly <= 8'd0;
    setc(0, 3'h0, 3'h4, 2'h1, 3'h0, 1'b0);
    acc(1'b1, 1'b0, A0);
    check("write waitstates", g_len, base + 4);
    h0 = g_hc;
    setc(0, 3'h0, 3'h4, 2'h1, 3'h0, 1'b1);
    acc(1'b1, 1'b0, A0);
    check("write hold cycle", g_hc - h0, 1);
    setc(0, 3'h0, 3'h0, 2'h2, 3'h0, 1'b0);
    acc(1'b1, 1'b0, A0);
    h0 = g_hc;
    setc(0, 3'h0, 3'h0, 2'h2, 3'h0, 1'b1);
    acc(1'b1, 1'b0, A0);
    check("hold in both mode", g_hc - h0, 1);
    setc(0, 3'h0, 3'h7, 2'h1, 3'h5, 1'b0);
    fork
      acc(1'b1, 1'b0, A0);
      begin
        for (int n = 0; n < 400 && wr_n !== 1'b0; n++) @(posedge clk);
        apb(1'b0, `EPC_OFF_ESTAT, 32'h0);
        check("write pending", r[8], 1'b1);
      end
    join
    apb(1'b0, `EPC_OFF_ESTAT, 32'h0);
    check("write done", r[8], 1'b0);
  endtask : t_write

  // Far master takes the bus, idle or mid access; request pin changes on clk edges
  task automatic t_grant(input logic busy);
    int n;
    if (busy) begin
      setc(0, 3'h0, 3'h0, 2'h0, 3'h0, 1'b0);
      ack_dly <= 8'd30;
      fork
        acc(1'b0, 1'b0, A0);
        begin
          for (n = 0; n < 50 && rd_n !== 1'b0; n++) @(posedge clk);
          apb(1'b0, `EPC_OFF_PSTAT, 32'h0);
          check("busy on-chip", r[1:0], 2'h2);
          check("current master", r[6:2], 5'h0B);
          bus_request_n <= 1'b0;
        end
      join
      check("no grant mid access", overlap, 1'b0);
    end else begin
      packer_fill   <= 2'h2;
      bus_request_n <= 1'b0;
      for (n = 0; n < 20 && bus_grant_n !== 1'b0; n++) @(posedge clk);
      check("request synchronised", n >= 3, 1);
    end
    for (n = 0; n < 20 && bus_grant_n !== 1'b0; n++) @(posedge clk);
    check("grant", bus_grant_n, 1'b0);
    check("drivers off", {mem_addr_oe, mem_data_oe, select_oe, strobe_oe},
          4'h0);
    apb(1'b0, `EPC_OFF_PSTAT, 32'h0);
    check("status word", r[8:0], {2'h2, 5'h1F, 2'h1});
    bus_request_n <= 1'b1;
    for (n = 0; n < 20 && bus_grant_n !== 1'b1; n++) @(posedge clk);
    check("grant released", bus_grant_n, 1'b1);
    repeat (2) @(posedge clk);
    check("drivers back", {mem_addr_oe, select_oe, strobe_oe}, 3'h7);
  endtask : t_grant

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // Cut a hang short
  initial begin
    #1500000;
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    {ce, bus_request_n} = 2'b11;
    {reset_n, psel, penable, pwrite, overlap} = '0;
    {req_valid, req_write, req_io, req_dm} = '0;
    {paddr, pwdata, req_addr, req_wdata, packer_fill} = '0;
    req_mid = 5'h0B;
    ack_dly = 8'd20;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_decode();
    t_modes();
    t_div();
    t_write();
    t_grant(1'b0);
    t_grant(1'b1);
    complete_run();
  end
endmodule : external_memory_port_control_bench
